//--- src/sbc_consts.svh
// Contract
// [RULE1] Rules apply only with clock enable steady high
// [RULE2] Idle only after precharge period elapsed
// [RULE3] Row active after activate delay, no burst
// [RULE4] Read/write state lasts until burst ends
// [RULE5] No same-bank commands during busy states
// [RULE6] Precharging lasts precharge period, then idle
// [RULE7] Activating lasts activate delay, then row active
// [RULE8] Auto-precharge burst ends idle after precharge period
// [RULE9] Only NOP during refresh, mode load, precharge-all; cmd_error flags refresh and mode load, not precharge-all, plus terminate with no burst
// [RULE10] Refresh lasts refresh cycle time, all idle
// [RULE11] Mode load lasts mode load delay, all idle
// [RULE12] Precharge-all makes every bank idle after period
// [RULE13] No unlisted state and command combinations
// [RULE14] Refresh or mode load only when all idle
// [RULE15] Precharge-all only from permitted bank states
// [RULE16] Burst terminate hits most recent burst only
// [RULE17] Precharge to idle bank is a no-op
// [RULE18] Interrupted auto-precharge burst self-precharges
// [RULE19] Read-to-read bank handover after read latency
// [RULE20] Mask one clock before write after read
// [RULE21] Mask two clocks before write after auto read
// [RULE22] New command interrupts write when registered
// [RULE23] Select bit high precharges all banks
// [RULE24] Select bit enables auto precharge per burst
// [RULE25] Controller keeps per-bank and global timers
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH
`define SBC_NBANKS      4
`define SBC_CNT_W       4
`define SBC_T_RP        4'h3
`define SBC_T_RCD       4'h3
`define SBC_T_MRD       4'h2
`define SBC_T_RC        4'h8
`define SBC_T_WR        4'h2
`define SBC_T_XSR       4'h8
`define SBC_BURST_LEN   4'h4
`define SBC_READ_LAT    4'h3
`define SBC_ONE         4'h1
`define SBC_CMD_W       4
`define SBC_FIFO_DEPTH  8
`endif

//--- src/sbc_pkg.sv
package sbc_pkg;
  typedef enum logic [2:0] {
    SBC_CMD_NOP, SBC_CMD_ACT, SBC_CMD_RD, SBC_CMD_WR,
    SBC_CMD_BST, SBC_CMD_PRE, SBC_CMD_REF, SBC_CMD_MRS
  } sbc_cmd_type;
  typedef enum logic [3:0] {
    SBC_IDLE, SBC_ACTIVATING, SBC_ROW_ACTIVE, SBC_READ, SBC_WRITE,
    SBC_READ_AP, SBC_WRITE_AP, SBC_WR_RECOVER, SBC_PRECHARGING
  } sbc_bank_state_type;
endpackage : sbc_pkg

//--- src/sbc_cmd_if.sv
`timescale 1ns/100ps
// Decoded command stream between the pin stage and the tracker
interface sbc_cmd_if;
  import sbc_pkg::*;
  logic        valid;
  logic        ready;
  logic [7:0]  word;
  modport src  (output valid, output word, input ready);
  modport sink (input valid, input word, output ready);
endinterface : sbc_cmd_if

//--- src/sbc_fifo.sv
`timescale 1ns/100ps
module sbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Handshake terms
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rptr];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sbc_fifo

//--- src/sbc_bank_tracker.sv
`timescale 1ns/100ps
`include "sbc_consts.svh"
module sbc_bank_tracker
  import sbc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Command pins
  input  wire logic       cke,
  input  wire logic       cs_n,
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic [1:0] bank_select_lines,
  input  wire logic       auto_precharge_select_bit,
  input  wire logic       sr_exit,
  // Status
  output logic [3:0]      bank_idle,
  output logic [3:0]      bank_row_active,
  output logic            all_idle,
  output logic            global_busy,
  output logic            read_data_start,
  output logic            cmd_error,
  output logic            stall
);
  // Pin synchronisers
  logic [8:0] pin_s1;
  logic [8:0] pin_s2;
  logic       cke_prev;
  logic       cke_now;
  logic       sr_now;
  logic       rules_on;
  sbc_cmd_type cmd_dec;
  sbc_cmd_if  cif ();

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1 <= 9'h1E0;
      pin_s2 <= 9'h1E0;
    end else begin
      pin_s1 <= {cs_n, ras_n, cas_n, we_n, bank_select_lines,
                 auto_precharge_select_bit, cke, sr_exit};
      pin_s2 <= pin_s1;
    end
  end
  assign cke_now = pin_s2[1];
  assign sr_now  = pin_s2[0];

  // Command decode from synchronised pins
  always_comb begin
    case (pin_s2[8:5])
      4'h3:    cmd_dec = SBC_CMD_ACT;
      4'h5:    cmd_dec = SBC_CMD_RD;
      4'h4:    cmd_dec = SBC_CMD_WR;
      4'h6:    cmd_dec = SBC_CMD_BST;
      4'h2:    cmd_dec = SBC_CMD_PRE;
      4'h1:    cmd_dec = SBC_CMD_REF;
      4'h0:    cmd_dec = SBC_CMD_MRS;
      default: cmd_dec = SBC_CMD_NOP;
    endcase
  end

  // Self refresh exit delay and clock enable history
  logic [`SBC_CNT_W-1:0] xsr_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cke_prev <= 1'b0;
      xsr_cnt  <= '0;
    end else begin
      cke_prev <= cke_now;
      if (sr_now) begin
        xsr_cnt <= `SBC_T_XSR;
      end else if (xsr_cnt != '0) begin
        xsr_cnt <= xsr_cnt - `SBC_ONE;
      end
    end
  end
  assign rules_on = cke_prev && cke_now && (xsr_cnt == '0); // RULE1

  // Commands queue here; out_ready is tied high, so the tracker never applies back-pressure
  sbc_fifo #(.WIDTH(8), .DEPTH(`SBC_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (rules_on && (cmd_dec != SBC_CMD_NOP)),
    .in_ready  (cif.ready),
    .in_data   ({2'b00, 3'(cmd_dec), pin_s2[4:2]}),
    .out_valid (cif.valid),
    .out_ready (1'b1), // Tracker takes one command every cycle
    .out_data  (cif.word)
  );

  // Unpacked command from the queue
  sbc_cmd_type c_cmd;
  logic [1:0]  c_bank;
  logic        c_ap;
  logic        take;
  assign c_cmd  = sbc_cmd_type'(cif.word[5:3]);
  assign c_bank = cif.word[2:1];
  assign c_ap   = cif.word[0]; // RULE24
  assign take   = cif.valid;

  // Per-bank state and timers
  sbc_bank_state_type    bst  [`SBC_NBANKS];
  logic [`SBC_CNT_W-1:0] bcnt [`SBC_NBANKS];
  logic [`SBC_CNT_W-1:0] gcnt;
  logic [1:0]            last_bank;
  logic                  last_valid;
  logic [`SBC_NBANKS-1:0] hit;
  logic [`SBC_NBANKS-1:0] idle_v;
  logic [`SBC_NBANKS-1:0] act_v;
  logic [`SBC_NBANKS-1:0] burst_v;
  logic                   is_burst;
  assign is_burst = take && (c_cmd == SBC_CMD_RD || c_cmd == SBC_CMD_WR);

  // Global refresh and mode load timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gcnt <= '0;
    end else if (take && c_cmd == SBC_CMD_REF && (&idle_v)) begin
      gcnt <= `SBC_T_RC; // RULE10
    end else if (take && c_cmd == SBC_CMD_MRS && (&idle_v)) begin
      gcnt <= `SBC_T_MRD; // RULE11
    end else if (gcnt != '0) begin
      gcnt <= gcnt - `SBC_ONE;
    end
  end

  // Most recent burst owner for terminate
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_bank  <= '0;
      last_valid <= 1'b0;
    end else if (is_burst) begin
      last_bank  <= c_bank; // RULE16
      last_valid <= 1'b1;
    end else if (take && c_cmd == SBC_CMD_BST) begin
      last_valid <= 1'b0;
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < `SBC_NBANKS; gb++) begin : g_bank
      logic mine;
      logic pre_hit;
      assign mine    = take && (c_bank == 2'(gb));
      assign pre_hit = take && c_cmd == SBC_CMD_PRE && (c_ap || c_bank == 2'(gb)); // RULE23
      assign idle_v[gb]  = (bst[gb] == SBC_IDLE); // RULE2
      assign act_v[gb]   = (bst[gb] == SBC_ROW_ACTIVE); // RULE3
      assign burst_v[gb] = (bst[gb] == SBC_READ || bst[gb] == SBC_WRITE);
      assign hit[gb]     = mine;

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          bst[gb]  <= SBC_IDLE;
          bcnt[gb] <= '0;
        end else begin
          case (bst[gb])
            SBC_IDLE: begin
              if (mine && c_cmd == SBC_CMD_ACT && gcnt == '0) begin
                bst[gb]  <= SBC_ACTIVATING; // RULE7
                bcnt[gb] <= `SBC_T_RCD;
              end
            end
            SBC_ACTIVATING, SBC_PRECHARGING: begin
              if (bcnt[gb] > `SBC_ONE) begin
                bcnt[gb] <= bcnt[gb] - `SBC_ONE;
              end else begin
                bcnt[gb] <= '0;
                bst[gb]  <= (bst[gb] == SBC_ACTIVATING) ? SBC_ROW_ACTIVE : SBC_IDLE; // RULE6
              end
            end
            SBC_ROW_ACTIVE, SBC_READ, SBC_WRITE: begin
              if (pre_hit) begin
                bst[gb]  <= SBC_PRECHARGING; // RULE12
                bcnt[gb] <= `SBC_T_RP;
              end else if (mine && c_cmd == SBC_CMD_RD) begin
                bst[gb]  <= c_ap ? SBC_READ_AP : SBC_READ; // RULE4
                bcnt[gb] <= `SBC_BURST_LEN;
              end else if (mine && c_cmd == SBC_CMD_WR) begin
                bst[gb]  <= c_ap ? SBC_WRITE_AP : SBC_WRITE;
                bcnt[gb] <= `SBC_BURST_LEN;
              end else if (bst[gb] != SBC_ROW_ACTIVE) begin
                if ((take && c_cmd == SBC_CMD_BST && last_valid && last_bank == 2'(gb))
                    || is_burst || bcnt[gb] <= `SBC_ONE) begin
                  bst[gb]  <= SBC_ROW_ACTIVE; // RULE22
                  bcnt[gb] <= '0;
                end else begin
                  bcnt[gb] <= bcnt[gb] - `SBC_ONE;
                end
              end
            end
            SBC_READ_AP: begin
              if (is_burst || bcnt[gb] <= `SBC_ONE) begin
                bst[gb]  <= SBC_PRECHARGING; // RULE18
                bcnt[gb] <= `SBC_T_RP; // RULE8
              end else begin
                bcnt[gb] <= bcnt[gb] - `SBC_ONE;
              end
            end
            SBC_WRITE_AP: begin
              if (is_burst || bcnt[gb] <= `SBC_ONE) begin
                bst[gb]  <= SBC_WR_RECOVER; // RULE18
                bcnt[gb] <= `SBC_T_WR;
              end else begin
                bcnt[gb] <= bcnt[gb] - `SBC_ONE;
              end
            end
            SBC_WR_RECOVER: begin
              if (bcnt[gb] > `SBC_ONE) begin
                bcnt[gb] <= bcnt[gb] - `SBC_ONE;
              end else begin
                bst[gb]  <= SBC_PRECHARGING;
                bcnt[gb] <= `SBC_T_RP;
              end
            end
            default: begin
              bst[gb]  <= SBC_IDLE;
              bcnt[gb] <= '0;
            end
          endcase
        end
      end
    end
  endgenerate

  // Read data window start after read latency
  logic [`SBC_CNT_W-1:0] rl_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rl_cnt <= '0;
    end else if (take && c_cmd == SBC_CMD_RD) begin
      rl_cnt <= `SBC_READ_LAT; // RULE19
    end else if (rl_cnt != '0) begin
      rl_cnt <= rl_cnt - `SBC_ONE;
    end
  end

  // Registered status outputs; precharge to idle bank changes nothing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bank_idle       <= 4'hF;
      bank_row_active <= 4'h0;
      all_idle        <= 1'b1;
      global_busy     <= 1'b0;
      read_data_start <= 1'b0;
      cmd_error       <= 1'b0;
      stall           <= 1'b0;
    end else begin
      bank_idle       <= idle_v; // RULE17
      bank_row_active <= act_v;
      all_idle        <= (&idle_v) && gcnt == '0;
      global_busy     <= (gcnt != '0);
      read_data_start <= (rl_cnt == `SBC_ONE);
      cmd_error       <= take && ((gcnt != '0)
                          || ((c_cmd == SBC_CMD_REF || c_cmd == SBC_CMD_MRS) && !(&idle_v))
                          || (c_cmd == SBC_CMD_BST && !last_valid)); // RULE14
      stall           <= !cif.ready;
    end
  end

  // Assertions
  property p_idle_after_pre;
    @(posedge clk) disable iff (!rstn)
      (take && c_cmd == SBC_CMD_PRE && c_ap && act_v[0])
      |=> (bst[0] == SBC_PRECHARGING) ##3 (bst[0] == SBC_IDLE);
  endproperty
  a_idle_after_pre: assert property (p_idle_after_pre) // RULE6
    else $error("precharge did not end idle after period");

  property p_act_timing;
    @(posedge clk) disable iff (!rstn)
      (bst[0] == SBC_IDLE && hit[0] && c_cmd == SBC_CMD_ACT && gcnt == '0)
      |=> (bst[0] == SBC_ACTIVATING)[*3] ##1 (bst[0] == SBC_ROW_ACTIVE);
  endproperty
  a_act_timing: assert property (p_act_timing) // RULE7
    else $error("activate delay wrong");

  property p_ref_busy;
    @(posedge clk) disable iff (!rstn)
      (take && c_cmd == SBC_CMD_REF && (&idle_v) && gcnt == '0)
      |=> (gcnt == `SBC_T_RC) ##8 (gcnt == '0);
  endproperty
  a_ref_busy: assert property (p_ref_busy) // RULE10
    else $error("refresh timer not loaded");

  property p_read_lat;
    @(posedge clk) disable iff (!rstn)
      (take && c_cmd == SBC_CMD_RD) |-> ##4 read_data_start;
  endproperty
  a_read_lat: assert property (p_read_lat) // RULE19
    else $error("read data start misplaced");

  property p_ap_interrupt;
    @(posedge clk) disable iff (!rstn)
      (bst[1] == SBC_READ_AP && is_burst && c_bank != 2'd1)
      |=> (bst[1] == SBC_PRECHARGING);
  endproperty
  a_ap_interrupt: assert property (p_ap_interrupt) // RULE18
    else $error("interrupted auto precharge burst did not precharge");

  property p_pre_idle_nop;
    @(posedge clk) disable iff (!rstn)
      (bst[2] == SBC_IDLE && take && c_cmd == SBC_CMD_PRE) |=> (bst[2] == SBC_IDLE);
  endproperty
  a_pre_idle_nop: assert property (p_pre_idle_nop) // RULE17
    else $error("precharge changed idle bank");

  property p_rules_gate;
    @(posedge clk) disable iff (!rstn)
      (!cke_prev) |=> $stable(u_fifo.wptr);
  endproperty
  a_rules_gate: assert property (p_rules_gate) // RULE1
    else $error("commands honoured without steady clock enable");

  property p_bst_last;
    @(posedge clk) disable iff (!rstn)
      (take && c_cmd == SBC_CMD_BST && last_valid
       && (bst[last_bank] == SBC_READ || bst[last_bank] == SBC_WRITE))
      |=> (bst[$past(last_bank)] == SBC_ROW_ACTIVE);
  endproperty
  a_bst_last: assert property (p_bst_last) // RULE16
    else $error("terminate missed most recent burst");

  // Busy timers and refusals while a global operation runs
  property p_mode_busy;
    @(posedge clk) disable iff (!rstn)
      (take && c_cmd == SBC_CMD_MRS && (&idle_v) && gcnt == '0)
      |=> (gcnt == `SBC_T_MRD) ##2 (gcnt == '0);
  endproperty
  a_mode_busy: assert property (p_mode_busy) // RULE11
    else $error("mode load timer wrong");

  property p_busy_refused;
    @(posedge clk) disable iff (!rstn)
      (take && gcnt != '0 && c_cmd == SBC_CMD_ACT)
      |=> (cmd_error && (&idle_v));
  endproperty
  a_busy_refused: assert property (p_busy_refused) // RULE9
    else $error("activate honoured during global busy");
endmodule : sbc_bank_tracker

//--- src/sbc_unused.sv
`timescale 1ns/100ps

//--- verification/sbc_ctrl_model.sv
`timescale 1ns/100ps
module sbc_ctrl_model
  import sbc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Request from the bench
  input  wire sbc_cmd_type req_cmd,
  input  wire logic        req_inhibit,
  // Command pins
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n
);
  logic [2:0] junk = 3'h0;

  // Changing pattern on lines that do not count while deselected
  always @(negedge clk) begin
    junk <= junk + 3'h5;
  end

  // Only listed pin combinations are ever produced
  always_comb begin
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = 3'h7;
    case (req_cmd)
      SBC_CMD_ACT: {ras_n, cas_n, we_n} = 3'h3;
      SBC_CMD_RD:  {ras_n, cas_n, we_n} = 3'h5;
      SBC_CMD_WR:  {ras_n, cas_n, we_n} = 3'h4;
      SBC_CMD_BST: {ras_n, cas_n, we_n} = 3'h6;
      SBC_CMD_PRE: {ras_n, cas_n, we_n} = 3'h2;
      SBC_CMD_REF: {ras_n, cas_n, we_n} = 3'h1;
      SBC_CMD_MRS: {ras_n, cas_n, we_n} = 3'h0;
      default: begin
        if (req_inhibit) begin
          cs_n = 1'b1;
          {ras_n, cas_n, we_n} = junk;
        end
      end
    endcase
  end
endmodule : sbc_ctrl_model

//--- verification/sdram_bank_command_rules_bench.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module sdram_bank_command_rules_bench
  import sbc_pkg::*;
;
  // Clock, reset and stimulus
  logic        clk, rstn, cke, sr_exit, ap, inh;
  logic [1:0]  bsel, b;
  sbc_cmd_type cmd;
  logic        cs_n, ras_n, cas_n, we_n;
  logic [3:0]  bank_idle, bank_row_active;
  logic        all_idle, global_busy, read_data_start, cmd_error, stall;
  int          seed, fail_count, total_checks, busy_cnt, rd_cnt, err_cnt, stall_cnt, i;

  sbc_ctrl_model PARTNER (.clk(clk), .req_cmd(cmd), .req_inhibit(inh), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));
  sbc_bank_tracker DUT (.clk(clk), .rstn(rstn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select_lines(bsel), .auto_precharge_select_bit(ap),
    .sr_exit(sr_exit), .bank_idle(bank_idle), .bank_row_active(bank_row_active),
    .all_idle(all_idle), .global_busy(global_busy), .read_data_start(read_data_start),
    .cmd_error(cmd_error), .stall(stall));

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pulse counters
  always @(posedge clk) begin
    if (global_busy === 1'b1) busy_cnt++;
    if (read_data_start === 1'b1) rd_cnt++;
    if (cmd_error === 1'b1) err_cnt++;
    if (stall === 1'b1) stall_cnt++;
  end

  function automatic logic [3:0] emask(input logic [1:0] bk);
    emask = 4'h1 << bk;
  endfunction : emask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // Idle cycles, randomly inhibit or no-operation
  task automatic gap(input int n);
    repeat (n) begin
      @(negedge clk);
      inh = 1'($random(seed));
    end
  endtask : gap

  task automatic issue(input sbc_cmd_type c, input logic [1:0] bk, input logic a);
    @(negedge clk);
    inh = 1'b0;
    cmd = c;
    bsel = bk;
    ap = a;
    @(negedge clk);
    cmd = SBC_CMD_NOP;
  endtask : issue

  // Watchdog
  initial begin
    #(8 * 8000);
    fail_count++;
    $display("[ERR] watchdog expected finish seen hang");
    results();
  end

  initial begin
    seed = 29923;
    {rstn, cke, sr_exit, ap, inh, bsel} = '0;
    cmd = SBC_CMD_NOP;
    {fail_count, total_checks, busy_cnt, rd_cnt, err_cnt, stall_cnt} = '0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    cke = 1'b1;
    gap(2);
    `CHK("reset_idle", 4'hF, bank_idle)
    `CHK("reset_all_idle", 1'b1, all_idle)
    // Activate then precharge one bank
    b = 2'($random(seed));
    issue(SBC_CMD_ACT, b, 1'b0);
    gap(4);
    `CHK("act_idle", ~emask(b), bank_idle)
    `CHK("act_ra", 4'h0, bank_row_active)
    gap(3);
    `CHK("act_done", emask(b), bank_row_active)
    issue(SBC_CMD_PRE, b, 1'b0);
    gap(4);
    `CHK("pre_busy", ~emask(b), bank_idle)
    gap(3);
    `CHK("pre_done", 4'hF, bank_idle)
    // Precharge to an idle bank changes nothing
    issue(SBC_CMD_PRE, b + 2'h1, 1'b0);
    for (i = 0; i < 8; i++) begin
      gap(1);
      `CHK("pre_idle_nop", 4'hF, bank_idle)
    end
    $display("test act_pre done");
    // Two banks open, then precharge all
    issue(SBC_CMD_ACT, 2'h0, 1'b0);
    issue(SBC_CMD_ACT, 2'h1, 1'b0);
    gap(8);
    `CHK("two_open", 4'h3, bank_row_active)
    issue(SBC_CMD_PRE, 2'h2, 1'b1);
    gap(4);
    `CHK("preall_busy", 4'hC, bank_idle)
    gap(3);
    `CHK("preall_done", 4'hF, bank_idle)
    $display("test precharge_all done");
    // Reads with and without auto precharge
    b = 2'($random(seed));
    issue(SBC_CMD_ACT, b, 1'b0);
    gap(8);
    rd_cnt = 0;
    issue(SBC_CMD_RD, b, 1'b1);
    gap(25);
    `CHK("rd_ap_idle", 4'hF, bank_idle)
    `CHK("rd_start", 1, rd_cnt)
    issue(SBC_CMD_ACT, b, 1'b0);
    gap(8);
    issue(SBC_CMD_RD, b, 1'b0);
    gap(25);
    `CHK("rd_open", emask(b), bank_row_active)
    `CHK("rd_noap", ~emask(b), bank_idle)
    issue(SBC_CMD_WR, b, 1'b0);
    issue(SBC_CMD_BST, b, 1'b0);
    gap(10);
    `CHK("bst_open", emask(b), bank_row_active)
    issue(SBC_CMD_PRE, b, 1'b0);
    gap(10);
    $display("test burst done");
    // Refresh and mode load timers; refused command during refresh
    for (i = 0; i < 2; i++) begin
      busy_cnt = 0;
      err_cnt = 0;
      issue(i ? SBC_CMD_MRS : SBC_CMD_REF, 2'h0, 1'b0);
      if (i == 0) issue(SBC_CMD_ACT, 2'h3, 1'b0);
      gap(20);
      `CHK("busy_len", i ? 2 : 8, busy_cnt)
      `CHK("busy_err", i ? 0 : 1, err_cnt)
      `CHK("busy_idle", 4'hF, bank_idle)
    end
    $display("test refresh_mode done");
    // Clock enable low and self refresh exit hide commands
    cke = 1'b0;
    issue(SBC_CMD_ACT, 2'($random(seed)), 1'b0);
    gap(10);
    `CHK("cke_low", 4'hF, bank_idle)
    cke = 1'b1;
    gap(3);
    sr_exit = 1'b1;
    issue(SBC_CMD_ACT, 2'($random(seed)), 1'b0);
    sr_exit = 1'b0;
    gap(10);
    `CHK("exit_delay", 4'hF, bank_idle)
    `CHK("stall", 1'b0, stall)
    $display("test clock_enable done");
    // Back-to-back commands pass the queue in order
    for (i = 0; i < 4; i++) begin
      @(negedge clk);
      inh = 1'b0;
      cmd = SBC_CMD_ACT;
      bsel = 2'(i);
      ap = 1'b0;
    end
    @(negedge clk);
    cmd = SBC_CMD_NOP;
    gap(10);
    `CHK("queue_order", 4'hF, bank_row_active)
    $display("test queue done");
    // Read with auto precharge cut short by a write to another bank
    issue(SBC_CMD_RD, 2'h1, 1'b1);
    issue(SBC_CMD_WR, 2'h2, 1'b0);
    gap(7);
    `CHK("ap_cut_idle", 4'h2, bank_idle)
    gap(2);
    `CHK("wr_cut_open", 4'hD, bank_row_active)
    // Read then write to another bank, then precharge all
    issue(SBC_CMD_RD, 2'h3, 1'b0);
    issue(SBC_CMD_WR, 2'h0, 1'b0);
    issue(SBC_CMD_PRE, 2'h1, 1'b1);
    gap(8);
    `CHK("final_idle", 4'hF, bank_idle)
    `CHK("stall_never", 0, stall_cnt)
    $display("test interleave done");
    results();
  end
endmodule : sdram_bank_command_rules_bench
